/* File: hdl/wc_window_consts.svh */
`ifndef WC_WINDOW_CONSTS_SVH
`define WC_WINDOW_CONSTS_SVH

// register addresses on the special-function bus
`define WC_ADDR_NEG_SEL 8'hBA
`define WC_ADDR_CFG 8'hBC
`define WC_ADDR_RES_LO 8'hBD
`define WC_ADDR_RES_HI 8'hBE
`define WC_ADDR_LOWER_LO 8'hC3
`define WC_ADDR_LOWER_HI 8'hC4
`define WC_ADDR_UPPER_LO 8'hC5
`define WC_ADDR_UPPER_HI 8'hC6
`define WC_ADDR_CTRL 8'hE8

// field positions
`define WC_CTRL_WIN_BIT 3
`define WC_CFG_LJST_BIT 2
`define WC_CFG_SC_LSB 3

// reset values
`define WC_RST_NEG_SEL 5'h1_F
`define WC_RST_SC 5'h1_F
`define WC_RST_LJST 1'b0
`define WC_RST_LIMIT 8'h00

// negative input select code for ground (single-ended)
`define WC_NEG_GND 5'h1_1

// least conversion time, in sar clock periods
`define WC_CONV_SAR_CLOCKS 10

`endif

/* File: hdl/wc_window_pkg.sv */
`default_nettype none
package wc_window_pkg;

    // one access on the special-function bus
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [7:0] wdata;
    } wc_sfr_req_t;

    // converter sequencing
    typedef enum logic [0:0] {
        WC_IDLE,
        WC_CONV
    } wc_state_t;

endpackage
`default_nettype wire

/* File: hdl/wc_window_comparator.sv */
`timescale 1ns/1ns
`default_nettype none
`include "wc_window_consts.svh"

// Summary of operation
// - compare every new result against both limits
// - two 16-bit read/write limits, byte split
// - inside: above lower and below upper
// - outside: below upper or above lower
// - limit order picks the mode, compared signed when differential
// - single-ended compares unsigned
// - differential compares signed two's complement
// - all ones reads as minus one when differential
// - flag readable and driven out as request
// - conversion lasts at least ten sar clocks
// - flag in control bit 3, sticky
// - justify bit picks result layout
// - ground negative input means single-ended
module wc_window_comparator #(
    parameter int CONV_SAR_CLOCKS = `WC_CONV_SAR_CLOCKS
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire wc_window_pkg::wc_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    input wire logic conv_start,
    input wire logic [9:0] conv_code,
    output logic conv_busy,
    output logic conv_done,
    output logic window_irq
);
    import wc_window_pkg::*;

    // refuse a conversion shorter than the converter can serve
    if (CONV_SAR_CLOCKS < `WC_CONV_SAR_CLOCKS || CONV_SAR_CLOCKS > 255) begin : g_bad_conv_len
        $error("CONV_SAR_CLOCKS out of range");
    end

    localparam logic [7:0] SAR_LAST = 8'(CONV_SAR_CLOCKS - 1);

    // software-visible state
    logic [7:0] lower_lo;
    logic [7:0] lower_hi;
    logic [7:0] upper_lo;
    logic [7:0] upper_hi;
    logic [4:0] negative_input_select;
    logic [4:0] sar_div;
    logic left_justify_select;
    logic window_match_flag;
    logic [15:0] result;

    // conversion sequencer
    wc_state_t state;
    wc_state_t next_state;
    logic [4:0] presc;
    logic [7:0] sar_cnt;

    // bus decode
    wire wr_neg = sfr_req.wr && sfr_req.addr == `WC_ADDR_NEG_SEL;
    wire wr_cfg = sfr_req.wr && sfr_req.addr == `WC_ADDR_CFG;
    wire wr_llo = sfr_req.wr && sfr_req.addr == `WC_ADDR_LOWER_LO;
    wire wr_lhi = sfr_req.wr && sfr_req.addr == `WC_ADDR_LOWER_HI;
    wire wr_ulo = sfr_req.wr && sfr_req.addr == `WC_ADDR_UPPER_LO;
    wire wr_uhi = sfr_req.wr && sfr_req.addr == `WC_ADDR_UPPER_HI;
    wire wr_ctrl = sfr_req.wr && sfr_req.addr == `WC_ADDR_CTRL;

    // full limit words
    wire [15:0] lower_word = {lower_hi, lower_lo};
    wire [15:0] upper_word = {upper_hi, upper_lo};

    // mode from the negative input selection
    wire differential = negative_input_select != `WC_NEG_GND;

    // sequencer timing: one sar clock is sar_div+1 system clocks
    wire presc_wrap = presc == sar_div;
    wire conv_end = state == WC_CONV && presc_wrap && sar_cnt == SAR_LAST;

    // result layout; single-ended codes are unsigned so extension is zero
    wire ext_bit = differential & conv_code[9];
    wire [15:0] right_word = {{6{ext_bit}}, conv_code};
    wire [15:0] left_word = {conv_code, 6'b00_0000};
    wire [15:0] next_result = left_justify_select ? left_word : right_word;

    // comparisons; bit 15 flipped turns signed order into unsigned order
    wire [15:0] sgn_flip = {differential, 15'h0000};
    wire [15:0] r_key = next_result ^ sgn_flip;
    wire [15:0] lo_key = lower_word ^ sgn_flip;
    wire [15:0] up_key = upper_word ^ sgn_flip;
    wire above_lower = r_key > lo_key;
    wire below_upper = r_key < up_key;
    wire inside_mode = up_key > lo_key;

    // match condition for the selected mode
    wire in_hit = above_lower && below_upper;
    wire out_hit = above_lower || below_upper;
    wire window_hit = inside_mode ? in_hit : out_hit;

    // flag update: a match in the clearing cycle wins
    wire flag_set = conv_end && window_hit;
    wire flag_wr_val = sfr_req.wdata[`WC_CTRL_WIN_BIT];
    wire next_flag = flag_set ? 1'b1 : (wr_ctrl ? flag_wr_val : window_match_flag);

    // read mux; unmapped addresses and unused bits read zero
    wire [7:0] rd_cfg = {sar_div, left_justify_select, 2'b00};
    wire [7:0] rd_ctrl = {4'h0, window_match_flag, 3'b000};
    wire [7:0] next_rdata =
        sfr_req.addr == `WC_ADDR_NEG_SEL ? {3'b000, negative_input_select} :
        sfr_req.addr == `WC_ADDR_CFG ? rd_cfg :
        sfr_req.addr == `WC_ADDR_RES_LO ? result[7:0] :
        sfr_req.addr == `WC_ADDR_RES_HI ? result[15:8] :
        sfr_req.addr == `WC_ADDR_LOWER_LO ? lower_lo :
        sfr_req.addr == `WC_ADDR_LOWER_HI ? lower_hi :
        sfr_req.addr == `WC_ADDR_UPPER_LO ? upper_lo :
        sfr_req.addr == `WC_ADDR_UPPER_HI ? upper_hi :
        sfr_req.addr == `WC_ADDR_CTRL ? rd_ctrl : 8'h00;

    // next state of the sequencer
    always_comb begin
        next_state = state;
        case (state)
            WC_IDLE: begin
                if (conv_start) begin
                    next_state = WC_CONV;
                end
            end
            WC_CONV: begin
                if (conv_end) begin
                    next_state = WC_IDLE;
                end
            end
            default: begin
                next_state = WC_IDLE;
            end
        endcase
    end

    // limit registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            lower_lo <= `WC_RST_LIMIT;
            lower_hi <= `WC_RST_LIMIT;
            upper_lo <= `WC_RST_LIMIT;
            upper_hi <= `WC_RST_LIMIT;
        end else begin
            if (wr_llo) lower_lo <= sfr_req.wdata;
            if (wr_lhi) lower_hi <= sfr_req.wdata;
            if (wr_ulo) upper_lo <= sfr_req.wdata;
            if (wr_uhi) upper_hi <= sfr_req.wdata;
        end
    end

    // configuration registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            negative_input_select <= `WC_RST_NEG_SEL;
            sar_div <= `WC_RST_SC;
            left_justify_select <= `WC_RST_LJST;
        end else begin
            if (wr_neg) negative_input_select <= sfr_req.wdata[4:0];
            if (wr_cfg) sar_div <= sfr_req.wdata[7:`WC_CFG_SC_LSB];
            if (wr_cfg) left_justify_select <= sfr_req.wdata[`WC_CFG_LJST_BIT];
        end
    end

    // sequencer; config writes mid-conversion take effect at once
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state <= WC_IDLE;
            presc <= 5'h00;
            sar_cnt <= 8'h00;
        end else begin
            state <= next_state;
            presc <= (state != WC_CONV || presc_wrap) ? 5'h00 : presc + 5'h01;
            if (state != WC_CONV) begin
                sar_cnt <= 8'h00;
            end else if (presc_wrap) begin
                sar_cnt <= sar_cnt + 8'h01;
            end
        end
    end

    // result capture, flag and outputs
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            result <= 16'h0000;
            window_match_flag <= 1'b0;
            sfr_rdata <= 8'h00;
            conv_busy <= 1'b0;
            conv_done <= 1'b0;
            window_irq <= 1'b0;
        end else begin
            if (conv_end) result <= next_result;
            window_match_flag <= next_flag;
            sfr_rdata <= next_rdata;
            conv_busy <= next_state == WC_CONV;
            conv_done <= conv_end;
            window_irq <= next_flag;
        end
    end

    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    // helper: cycles spent converting, capped
    logic [15:0] conv_cycles;
    always_ff @(posedge sys_clk) begin
        if (!rstn || state != WC_CONV) begin
            conv_cycles <= 16'h0000;
        end else if (conv_cycles != 16'hFFFF) begin
            conv_cycles <= conv_cycles + 16'h0001;
        end
    end
    wire [15:0] min_cycles = 16'(CONV_SAR_CLOCKS) * 16'({11'h000, sar_div} + 16'h0001);

    // helper: independent signed/unsigned compare
    wire signed [16:0] h_r = differential ? 17'($signed(next_result)) : {1'b0, next_result};
    wire signed [16:0] h_lo = differential ? 17'($signed(lower_word)) : {1'b0, lower_word};
    wire signed [16:0] h_up = differential ? 17'($signed(upper_word)) : {1'b0, upper_word};

    chk_inside_sets_flag: assert property (
        conv_end && h_up > h_lo && h_r > h_lo && h_r < h_up |=> window_match_flag && window_irq)
        else $error("inside match did not set flag");
    chk_outside_sets_flag: assert property (
        conv_end && h_up <= h_lo && (h_r < h_up || h_r > h_lo) |=> window_match_flag)
        else $error("outside match did not set flag");
    chk_no_hit_keeps: assert property (
        conv_end && !wr_ctrl && (h_up > h_lo ? !(h_r > h_lo && h_r < h_up)
            : !(h_r < h_up || h_r > h_lo)) |=> window_match_flag == $past(window_match_flag))
        else $error("flag changed without match");
    chk_flag_sticky: assert property (
        window_match_flag && !wr_ctrl |=> window_match_flag [*1])
        else $error("flag cleared without software");
    chk_conv_min_time: assert property (
        conv_end |-> conv_cycles + 16'h0001 >= min_cycles)
        else $error("conversion shorter than minimum");
    chk_left_zero_low: assert property (
        conv_end && left_justify_select |=> result[5:0] == 6'h00 && result[15:6] == $past(conv_code))
        else $error("left-justified result malformed");
    chk_minus_one_order: assert property (
        conv_end && differential && lower_word == 16'hFFFF && upper_word == 16'h0040
            && next_result == 16'h0000 |=> window_match_flag)
        else $error("minus one did not order below zero");
    chk_limit_write: assert property (
        wr_uhi ##1 !wr_uhi [*2] |-> upper_hi == $past(sfr_req.wdata, 2))
        else $error("upper high byte not stored");
    chk_done_pulse: assert property (
        conv_done |-> $past(state) == WC_CONV ##1 !conv_done)
        else $error("done not a single pulse");

    // converter side: results only move at the end of a conversion
    chk_result_holds: assert property (
        !conv_end |=> $stable(result))
        else $error("result changed outside conversion end");

    chk_busy_after_start: assert property (
        state == WC_IDLE && conv_start |=> conv_busy)
        else $error("start did not raise busy");

    // a start while converting must not restart the count
    chk_start_refused: assert property (
        state == WC_CONV && !conv_end |=> state == WC_CONV && sar_cnt >= $past(sar_cnt))
        else $error("conversion restarted while busy");

    chk_done_drops_busy: assert property (
        conv_done |-> !conv_busy)
        else $error("busy still high at done");

    // right-justified layout: sign extension only when differential
    chk_right_format: assert property (
        conv_end && !left_justify_select |=> result[9:0] == $past(conv_code)
            && result[15:10] == {6{$past(differential && conv_code[9])}})
        else $error("right-justified result malformed");

    chk_unsigned_zero_ext: assert property (
        conv_end && !differential && !left_justify_select |=> result[15:10] == 6'h00)
        else $error("single-ended result not zero extended");

    // flag clearing and its race with a match; the match must win
    chk_clear_write: assert property (
        wr_ctrl && !flag_wr_val && !flag_set |=> !window_match_flag)
        else $error("software clear ignored");

    chk_set_beats_clear: assert property (
        flag_set && wr_ctrl |=> window_match_flag)
        else $error("clear won over a match");

    chk_irq_mirrors_flag: assert property (
        window_irq == window_match_flag)
        else $error("request line differs from flag");

    chk_ctrl_readback: assert property (
        sfr_req.addr == `WC_ADDR_CTRL
            |=> sfr_rdata == {4'h0, $past(window_match_flag), 3'b000})
        else $error("flag not readable");

    chk_lower_write: assert property (
        wr_llo ##1 !wr_llo [*2] |-> lower_lo == $past(sfr_req.wdata, 2))
        else $error("lower low byte not stored");

endmodule

`default_nettype wire

/* File: tb/wc_adc_model.sv */
`timescale 1ns/1ns
`default_nettype none
// converter result side: holds its code for the whole conversion
module wc_adc_model (
    input wire logic conv_busy,
    input wire logic [9:0] code_in,
    output logic [9:0] conv_code
);
    // outside a conversion the code is stale, so show its inverse
    assign conv_code = conv_busy ? code_in : ~code_in;
endmodule
`default_nettype wire

/* File: tb/wc_window_comparator_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "wc_window_consts.svh"
module wc_window_comparator_tb_top;
    import wc_window_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    wc_sfr_req_t sfr_req = '0;
    logic conv_start = 1'b0;
    logic [9:0] code_in = 10'h000;
    logic [9:0] conv_code;
    logic [7:0] sfr_rdata;
    logic conv_busy, conv_done, window_irq;
    int failures = 0;
    int n_tests = 0;
    int exp_cycles = `WC_CONV_SAR_CLOCKS;
    logic poke = 1'b0;

    // 125 MHz system clock
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    wc_window_comparator wc_window_comparator_i (.sys_clk, .rstn, .sfr_req, .sfr_rdata,
        .conv_start, .conv_code, .conv_busy, .conv_done, .window_irq);
    wc_adc_model wc_adc_model_i (.conv_busy, .code_in, .conv_code);

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // strobe held one edge, then dropped; one idle cycle between writes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_req <= '{addr: a, wr: 1'b1, wdata: d};
        @(posedge sys_clk);
        sfr_req.wr <= 1'b0;
    endtask

    // read data is registered: look one edge after the address lands
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        sfr_req.addr <= a;
        @(posedge sys_clk);
        #1;
        chk(sfr_rdata, exp);
    endtask

    task automatic lim(input logic [15:0] lo, input logic [15:0] up);
        wr(`WC_ADDR_LOWER_LO, lo[7:0]);
        wr(`WC_ADDR_LOWER_HI, lo[15:8]);
        wr(`WC_ADDR_UPPER_LO, up[7:0]);
        wr(`WC_ADDR_UPPER_HI, up[15:8]);
    endtask

    // one conversion, flag optionally cleared first; poke pulses start mid-way
    task automatic conv(input logic [9:0] c, input logic clr, input logic f);
        int n;
        if (clr) begin
            wr(`WC_ADDR_CTRL, 8'h00);
        end
        @(posedge sys_clk);
        code_in <= c;
        conv_start <= 1'b1;
        @(posedge sys_clk);
        conv_start <= 1'b0;
        for (n = 1; n < 400; n++) begin
            @(posedge sys_clk);
            conv_start <= poke && n == 5;
            #1;
            if (n == 1) chk(conv_busy, 1'b1);
            if (conv_done === 1'b1) break;
        end
        if (n >= 400) begin
            failures++;
            test_done();
        end
        chk(16'(n), 16'(exp_cycles));
        chk(conv_busy, 1'b0);
        chk(window_irq, f);
    endtask

    task automatic t_reset();
        for (logic [7:0] a = 8'hC3; a <= 8'hC6; a++) rd(a, 8'h00);
        rd(`WC_ADDR_CFG, 8'hF8);
        rd(`WC_ADDR_CTRL, 8'h00);
        rd(`WC_ADDR_NEG_SEL, 8'h1F);
        rd(8'h00, 8'h00);
        chk({conv_busy, conv_done, window_irq}, 3'b000);
        $display("t_reset done");
    endtask

    task automatic t_regs();
        wr(`WC_ADDR_UPPER_LO, 8'hA5);
        wr(`WC_ADDR_LOWER_HI, 8'h5A);
        wr(`WC_ADDR_RES_LO, 8'hFF);
        wr(`WC_ADDR_NEG_SEL, 8'hF1);
        rd(`WC_ADDR_UPPER_LO, 8'hA5);
        rd(`WC_ADDR_LOWER_HI, 8'h5A);
        rd(`WC_ADDR_RES_LO, 8'h00);
        rd(`WC_ADDR_NEG_SEL, 8'h11);
        $display("t_regs done");
    endtask

    // single-ended, right-justified, inside window 0x40..0x80
    task automatic t_inside();
        wr(`WC_ADDR_CFG, 8'h00);
        lim(16'h0040, 16'h0080);
        conv(10'h040, 1'b1, 1'b0);
        conv(10'h041, 1'b1, 1'b1);
        conv(10'h080, 1'b0, 1'b1);
        rd(`WC_ADDR_CTRL, 8'h08);
        conv(10'h080, 1'b1, 1'b0);
        rd(`WC_ADDR_CTRL, 8'h00);
        conv(10'h07F, 1'b1, 1'b1);
        rd(`WC_ADDR_RES_HI, 8'h00);
        rd(`WC_ADDR_RES_LO, 8'h7F);
        $display("t_inside done");
    endtask

    // swapped and equal limits select outside flagging
    task automatic t_outside();
        lim(16'h0080, 16'h0040);
        conv(10'h03F, 1'b1, 1'b1);
        conv(10'h040, 1'b1, 1'b0);
        conv(10'h080, 1'b1, 1'b0);
        conv(10'h081, 1'b1, 1'b1);
        lim(16'h0050, 16'h0050);
        conv(10'h050, 1'b1, 1'b0);
        conv(10'h04F, 1'b1, 1'b1);
        $display("t_outside done");
    endtask

    // differential codes are sign-extended and compared signed
    task automatic t_diff();
        wr(`WC_ADDR_NEG_SEL, 8'h00);
        lim(16'hFFFF, 16'h0040);
        conv(10'h3FF, 1'b1, 1'b0);
        rd(`WC_ADDR_RES_HI, 8'hFF);
        conv(10'h000, 1'b1, 1'b1);
        conv(10'h200, 1'b1, 1'b0);
        lim(16'h0040, 16'hFFFF);
        conv(10'h3FF, 1'b1, 1'b0);
        wr(`WC_ADDR_NEG_SEL, 8'h11);
        conv(10'h3FF, 1'b1, 1'b1);
        $display("t_diff done");
    endtask

    // left-justified results need left-justified limits
    task automatic t_ljst();
        wr(`WC_ADDR_CFG, 8'h04);
        lim(16'h4000, 16'h4080);
        conv(10'h101, 1'b1, 1'b1);
        rd(`WC_ADDR_RES_HI, 8'h40);
        rd(`WC_ADDR_RES_LO, 8'h40);
        conv(10'h102, 1'b1, 1'b0);
        $display("t_ljst done");
    endtask

    // sar divider 1 doubles the conversion; a start while busy is ignored
    task automatic t_slow();
        wr(`WC_ADDR_CFG, 8'h08);
        lim(16'h0040, 16'h0080);
        exp_cycles = `WC_CONV_SAR_CLOCKS * 2;
        poke = 1'b1;
        conv(10'h050, 1'b1, 1'b1);
        poke = 1'b0;
        conv(10'h090, 1'b1, 1'b0);
        rd(`WC_ADDR_CFG, 8'h08);
        exp_cycles = `WC_CONV_SAR_CLOCKS;
        $display("t_slow done");
    endtask

    // reset for three cycles, then each scenario in turn
    initial begin
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        t_reset();
        t_regs();
        t_inside();
        t_outside();
        t_diff();
        t_ljst();
        t_slow();
        test_done();
    end
endmodule
`default_nettype wire
